/* File: svop_cfg.svh */
// Register map, field positions, reset values and timing counts of the video port
`ifndef SVOP_CFG_SVH
`define SVOP_CFG_SVH

`define SVOP_ADDR_COMMIT 8'h00
`define SVOP_ADDR_REV 8'h01
`define SVOP_ADDR_CFG1 8'h03
`define SVOP_ADDR_CLKGEN 8'h05
`define SVOP_ADDR_VM0 8'h06
`define SVOP_ADDR_VM1 8'h07
`define SVOP_ADDR_VM2 8'h08
`define SVOP_ADDR_COL_START 8'h10
`define SVOP_ADDR_COL_END 8'h11
`define SVOP_ADDR_WIN_LSB 8'h12

`define SVOP_COMMIT_BIT 0
`define SVOP_CFG1_FOLLOW_BIT 2
`define SVOP_CFG1_HSUB_BIT 5
`define SVOP_VM0_DRDY_BIT 0
`define SVOP_VM0_PCLK_FALL_BIT 1
`define SVOP_VM0_HPOL_BIT 2
`define SVOP_VM0_VPOL_BIT 3
`define SVOP_VM0_VPULSE_BIT 4
`define SVOP_VM0_ODDEVEN_BIT 5
`define SVOP_VM0_TRIG_LOW_BIT 6
`define SVOP_VM0_DRDY_HIGH_BIT 7
`define SVOP_VM1_FLOAT_BIT 0
`define SVOP_VM2_SHIFT_LSB 0
`define SVOP_VM2_WIDTH_LSB 2
`define SVOP_VM2_FLOAT_UNUSED_BIT 4

`define SVOP_RST_ZERO 8'h00
`define SVOP_RST_CLKGEN 8'h04
`define SVOP_RST_COL_END 8'hA5
`define SVOP_RST_WIN_LSB 8'h32

`define SVOP_WIDTH_10 2'h1
`define SVOP_WIDTH_8 2'h2
`define SVOP_UNUSED_10 12'h003
`define SVOP_UNUSED_8 12'h00F
`define SVOP_ALL_PINS 12'hFFF

`define SVOP_ROW_TRIG_BASE 9'h07C
`define SVOP_FRAME_PULSE_TICKS 3'h4

`endif

/* File: svop_pkg.sv */
// Types shared by the video port design
package svop_pkg;
    typedef logic [11:0] svop_pix_t;
    typedef logic [7:0] svop_byte_t;
    typedef enum logic [1:0] {
        SVOP_ROW_IDLE,
        SVOP_ROW_DELAY,
        SVOP_ROW_ACTIVE
    } svop_row_t;
endpackage

/* File: svop_fifo.sv */
// Small synchronous FIFO between the pixel framer and the output port
`timescale 1ns/100ps
`default_nettype none
module svop_fifo #(
    parameter int unsigned WIDTH = 12,
    parameter int unsigned DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0] count;
        logic full;
    } svop_fifo_state_t;

    svop_fifo_state_t s;
    svop_fifo_state_t next_s;
    logic push;
    logic pop;

    always_comb begin
        next_s = s;
        push = in_valid_i && !s.full;
        pop = out_ready_i && (s.count != '0);
        if (push) begin
            next_s.mem[s.wptr] = in_data_i;
            next_s.wptr = (s.wptr == AW'(DEPTH - 1)) ? '0 : s.wptr + 1'b1;
        end
        if (pop) begin
            next_s.rptr = (s.rptr == AW'(DEPTH - 1)) ? '0 : s.rptr + 1'b1;
        end
        // Simultaneous push and pop leaves the fill level alone
        if (push && !pop) begin
            next_s.count = s.count + 1'b1;
        end else if (pop && !push) begin
            next_s.count = s.count - 1'b1;
        end
        next_s.full = (next_s.count == (AW+1)'(DEPTH));
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign in_ready_o = !s.full;
    assign out_valid_o = (s.count != '0);
    assign out_data_o = s.mem[s.rptr];
endmodule // svop_fifo
`default_nettype wire

/* File: svop_video_port.sv */
// Digital video output port: pixel bus, pixel clock, syncs and commit logic
`include "svop_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module svop_video_port #(
    parameter int unsigned H_TOTAL = 800,
    parameter int unsigned V_ACTIVE = 488,
    parameter int unsigned V_TOTAL = 525,
    parameter int unsigned FIFO_DEPTH = 8,
    // Arbitrary revision value
    parameter logic [7:0] SILICON_REV = 8'h01
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output svop_pkg::svop_byte_t reg_rdata_o,
    input wire logic pix_valid_i,
    input wire svop_pkg::svop_pix_t pix_data_i,
    output logic pix_ready_o,
    output svop_pkg::svop_pix_t data_o,
    output logic [11:0] data_oe_n_o,
    output logic pclk_o,
    output logic pclk_oe_n_o,
    input wire logic hsync_i,
    output logic hsync_o,
    output logic hsync_oe_n_o,
    input wire logic vsync_i,
    output logic vsync_o,
    output logic vsync_oe_n_o
);
    import svop_pkg::*;

    typedef struct packed {
        logic [1:0] hs_sync;
        logic [1:0] vs_sync;
        logic hs_prev;
        logic vs_prev;
        svop_byte_t cfg1;
        svop_byte_t clkgen;
        svop_byte_t vm0;
        svop_byte_t vm1;
        svop_byte_t vm2;
        svop_byte_t col_start;
        svop_byte_t col_end;
        svop_byte_t win_lsb;
        svop_byte_t act_start;
        svop_byte_t act_end;
        logic pending;
        svop_byte_t rdata;
        logic [4:0] div;
        logic pclk_ph;
        logic [9:0] col;
        logic [9:0] row;
        logic field;
        svop_row_t fst;
        logic [8:0] dly;
        logic [2:0] fpulse;
        svop_pix_t dout;
        logic [11:0] doe_n;
        logic pclk;
        logic pclk_oe_n;
        logic hs;
        logic vs;
        logic sync_oe_n;
    } svop_state_t;

    svop_state_t s;
    svop_state_t next_s;

    logic fifo_valid;
    svop_pix_t fifo_data;
    logic pop;

    svop_fifo #(
        .WIDTH(12),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(pix_valid_i),
        .in_data_i(pix_data_i),
        .in_ready_o(pix_ready_o),
        .out_valid_o(fifo_valid),
        .out_data_o(fifo_data),
        .out_ready_i(pop)
    );

    logic follower;
    logic trig_h;
    logic trig_v;
    logic row_trig;
    logic frame_trig;
    logic [4:0] half_lim;
    logic half_tick;
    logic data_tick;
    logic [9:0] win_lo;
    logic [9:0] win_hi;
    logic in_rows;
    logic active_px;
    logic last_px;
    logic in_frame;
    logic apply;
    logic [8:0] row_delay;
    logic drdy_lvl;
    logic vs_assert;
    logic [14:0] wide;
    logic [11:0] unused_mask;

    always_comb begin
        next_s = s;
        pop = 1'b0;
        apply = 1'b0;
        follower = s.cfg1[`SVOP_CFG1_FOLLOW_BIT];
        // Only the second stage of each synchroniser is looked at
        next_s.hs_sync = {s.hs_sync[0], hsync_i};
        next_s.vs_sync = {s.vs_sync[0], vsync_i};
        trig_h = s.hs_sync[1] ^ s.vm0[`SVOP_VM0_TRIG_LOW_BIT];
        trig_v = s.vs_sync[1] ^ s.vm0[`SVOP_VM0_TRIG_LOW_BIT];
        next_s.hs_prev = trig_h;
        next_s.vs_prev = trig_v;
        // Edge detect: a long trigger from the processor starts one row only
        row_trig = follower && trig_h && !s.hs_prev;
        frame_trig = follower && trig_v && !s.vs_prev;

        // Pixel tick divider; subsampling doubles the half period
        if (s.cfg1[`SVOP_CFG1_HSUB_BIT]) begin
            half_lim = {s.clkgen[3:0], 1'b1};
        end else begin
            half_lim = {1'b0, s.clkgen[3:0]};
        end
        half_tick = (s.div >= half_lim);
        next_s.div = half_tick ? 5'h00 : s.div + 5'h01;
        data_tick = half_tick && !s.pclk_ph;
        if (half_tick) begin
            next_s.pclk_ph = !s.pclk_ph;
        end

        win_lo = {s.act_start, 2'b00};
        win_hi = {s.act_end, 2'b11};
        in_rows = (s.row < 10'(V_ACTIVE));
        if (follower) begin
            active_px = in_rows && (s.fst == SVOP_ROW_ACTIVE);
        end else begin
            active_px = in_rows && (s.col >= win_lo) && (s.col <= win_hi);
        end
        last_px = active_px && (s.row == 10'(V_ACTIVE - 1)) && (s.col == win_hi);
        in_frame = in_rows && !((s.row == 10'(V_ACTIVE - 1)) && (s.col > win_hi));
        row_delay = `SVOP_ROW_TRIG_BASE + {1'b0, s.act_start};

        // Row and frame sequencing
        if (follower) begin
            case (s.fst)
                SVOP_ROW_IDLE: begin
                    if (row_trig) begin
                        next_s.fst = SVOP_ROW_DELAY;
                        next_s.dly = 9'h001;
                    end
                end
                SVOP_ROW_DELAY: begin
                    next_s.dly = s.dly + 9'h001;
                    if (s.dly >= row_delay) begin
                        next_s.fst = SVOP_ROW_ACTIVE;
                        next_s.col = win_lo;
                    end
                end
                SVOP_ROW_ACTIVE: begin
                    if (data_tick) begin
                        next_s.col = s.col + 10'h001;
                        if (s.col >= win_hi) begin
                            next_s.fst = SVOP_ROW_IDLE;
                            next_s.row = s.row + 10'h001;
                        end
                    end
                end
                default: begin
                    next_s.fst = SVOP_ROW_IDLE;
                end
            endcase
            if (frame_trig) begin
                next_s.row = 10'h000;
                next_s.field = !s.field;
                apply = 1'b1;
            end
        end else begin
            next_s.fst = SVOP_ROW_IDLE;
            if (data_tick) begin
                if (s.col >= 10'(H_TOTAL - 1)) begin
                    next_s.col = 10'h000;
                    if (s.row >= 10'(V_TOTAL - 1)) begin
                        next_s.row = 10'h000;
                        next_s.field = !s.field;
                        apply = 1'b1;
                    end else begin
                        next_s.row = s.row + 10'h001;
                    end
                end else begin
                    next_s.col = s.col + 10'h001;
                end
            end
        end

        // Pixel words leave the FIFO only on a tick inside the active row
        if (data_tick) begin
            pop = active_px && fifo_valid;
            if (pop) begin
                wide = {3'b000, fifo_data} << s.vm2[`SVOP_VM2_SHIFT_LSB +: 2];
                // Saturate rather than wrap when the gain pushes bits out
                next_s.dout = (wide[14:12] != 3'b000) ? `SVOP_ALL_PINS : wide[11:0];
            end else begin
                wide = 15'h0000;
            end
            if (last_px) begin
                next_s.fpulse = `SVOP_FRAME_PULSE_TICKS;
            end else if (s.fpulse != 3'h0) begin
                next_s.fpulse = s.fpulse - 3'h1;
            end
            next_s.hs = active_px ? s.vm0[`SVOP_VM0_HPOL_BIT]
                                  : !s.vm0[`SVOP_VM0_HPOL_BIT];
            if (s.vm0[`SVOP_VM0_VPULSE_BIT]) begin
                vs_assert = (s.fpulse != 3'h0) || last_px;
            end else begin
                vs_assert = in_frame;
            end
            if (s.vm0[`SVOP_VM0_ODDEVEN_BIT]) begin
                vs_assert = vs_assert && s.field;
            end
            next_s.vs = vs_assert ? s.vm0[`SVOP_VM0_VPOL_BIT]
                                  : !s.vm0[`SVOP_VM0_VPOL_BIT];
        end else begin
            wide = 15'h0000;
            vs_assert = 1'b0;
        end

        // Pixel clock: when free-running, data and syncs change on the selected edge
        drdy_lvl = s.vm0[`SVOP_VM0_DRDY_HIGH_BIT];
        if (s.vm0[`SVOP_VM0_DRDY_BIT]) begin
            if (data_tick) begin
                next_s.pclk = pop ? drdy_lvl : !drdy_lvl;
            end else if (half_tick) begin
                next_s.pclk = !drdy_lvl;
            end
        end else if (half_tick) begin
            next_s.pclk = next_s.pclk_ph ^ s.vm0[`SVOP_VM0_PCLK_FALL_BIT];
        end

        // Output enables, active low
        if (s.vm2[`SVOP_VM2_WIDTH_LSB +: 2] == `SVOP_WIDTH_10) begin
            unused_mask = `SVOP_UNUSED_10;
        end else if (s.vm2[`SVOP_VM2_WIDTH_LSB +: 2] == `SVOP_WIDTH_8) begin
            unused_mask = `SVOP_UNUSED_8;
        end else begin
            unused_mask = 12'h000;
        end
        if (s.vm1[`SVOP_VM1_FLOAT_BIT]) begin
            next_s.doe_n = `SVOP_ALL_PINS;
        end else if (s.vm2[`SVOP_VM2_FLOAT_UNUSED_BIT]) begin
            next_s.doe_n = unused_mask;
        end else begin
            next_s.doe_n = 12'h000;
        end
        next_s.sync_oe_n = follower;
        next_s.pclk_oe_n = 1'b0;

        // Frame boundary copies the buffered window; a new request wins
        if (apply && s.pending) begin
            next_s.act_start = s.col_start;
            next_s.act_end = s.col_end;
            next_s.pending = 1'b0;
        end

        if (reg_wr_i) begin
            case (reg_addr_i)
                `SVOP_ADDR_COMMIT: begin
                    if (reg_wdata_i[`SVOP_COMMIT_BIT]) begin
                        next_s.pending = 1'b1;
                    end
                end
                `SVOP_ADDR_CFG1: next_s.cfg1 = reg_wdata_i;
                `SVOP_ADDR_CLKGEN: next_s.clkgen = reg_wdata_i;
                `SVOP_ADDR_VM0: next_s.vm0 = reg_wdata_i;
                `SVOP_ADDR_VM1: next_s.vm1 = reg_wdata_i;
                `SVOP_ADDR_VM2: next_s.vm2 = reg_wdata_i;
                `SVOP_ADDR_COL_START: next_s.col_start = reg_wdata_i;
                `SVOP_ADDR_COL_END: next_s.col_end = reg_wdata_i;
                `SVOP_ADDR_WIN_LSB: next_s.win_lsb = reg_wdata_i;
                default: begin
                    // Revision and unmapped addresses ignore writes
                end
            endcase
        end

        if (reg_rd_i) begin
            case (reg_addr_i)
                `SVOP_ADDR_COMMIT: next_s.rdata = {7'h00, s.pending};
                `SVOP_ADDR_REV: next_s.rdata = SILICON_REV;
                `SVOP_ADDR_CFG1: next_s.rdata = s.cfg1;
                `SVOP_ADDR_CLKGEN: next_s.rdata = s.clkgen;
                `SVOP_ADDR_VM0: next_s.rdata = s.vm0;
                `SVOP_ADDR_VM1: next_s.rdata = s.vm1;
                `SVOP_ADDR_VM2: next_s.rdata = s.vm2;
                `SVOP_ADDR_COL_START: next_s.rdata = s.col_start;
                `SVOP_ADDR_COL_END: next_s.rdata = s.col_end;
                `SVOP_ADDR_WIN_LSB: next_s.rdata = s.win_lsb;
                default: next_s.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0;
            s.clkgen <= `SVOP_RST_CLKGEN;
            s.col_end <= `SVOP_RST_COL_END;
            s.act_end <= `SVOP_RST_COL_END;
            s.win_lsb <= `SVOP_RST_WIN_LSB;
            s.fst <= SVOP_ROW_IDLE;
            // Idle levels: pclk high, syncs at inactive default levels
            s.pclk <= 1'b1;
            s.hs <= 1'b1;
            s.vs <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata_o = s.rdata;
    assign data_o = s.dout;
    assign data_oe_n_o = s.doe_n;
    assign pclk_o = s.pclk;
    assign pclk_oe_n_o = s.pclk_oe_n;
    assign hsync_o = s.hs;
    assign hsync_oe_n_o = s.sync_oe_n;
    assign vsync_o = s.vs;
    assign vsync_oe_n_o = s.sync_oe_n;
endmodule // svop_video_port
`default_nettype wire

/* File: svop_video_port_chk.sv */
// Checker for the video port's register, pixel clock and sync behaviour
`include "svop_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module svop_video_port_chk #(
    parameter logic [7:0] SILICON_REV = 8'h01
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire svop_pkg::svop_byte_t reg_rdata_o,
    input wire svop_pkg::svop_pix_t data_o,
    input wire logic [11:0] data_oe_n_o,
    input wire logic pclk_o,
    input wire logic hsync_o,
    input wire logic hsync_oe_n_o,
    input wire logic vsync_o,
    input wire logic vsync_oe_n_o
);
    import svop_pkg::*;
    typedef struct packed {
        logic [7:0] cfg1;
        logic [7:0] clkgen;
        logic [7:0] vm0;
        logic [6:0] age;
        logic [5:0] run;
        logic [7:0] vrun;
        logic pclk_q;
        logic vs_q;
    } svop_chk_t;
    svop_chk_t st;
    svop_chk_t next_st;
    logic ok;
    logic [5:0] half;
    // Mode changes land mid-line, so checks wait until settled
    assign ok = st.age == 7'h7F;
    assign half = st.cfg1[5] ? {1'b0, st.clkgen[3:0], 1'b0} + 6'h02 : {2'h0, st.clkgen[3:0]} + 6'h01;
    always_comb begin
        next_st = st;
        next_st.pclk_q = pclk_o;
        next_st.vs_q = vsync_o;
        next_st.run = (pclk_o != st.pclk_q) ? 6'h01 : st.run + {5'h00, st.run != 6'h3F};
        next_st.vrun = (vsync_o != st.vs_q) ? 8'h01 : st.vrun + {7'h00, st.vrun != 8'hFF};
        next_st.age = st.age + {6'h00, st.age != 7'h7F};
        if (reg_wr_i) begin
            next_st.age = 7'h00;
            if (reg_addr_i == `SVOP_ADDR_CFG1) next_st.cfg1 = reg_wdata_i;
            if (reg_addr_i == `SVOP_ADDR_CLKGEN) next_st.clkgen = reg_wdata_i;
            if (reg_addr_i == `SVOP_ADDR_VM0) next_st.vm0 = reg_wdata_i;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
            st.clkgen <= `SVOP_RST_CLKGEN;
        end else begin
            st <= next_st;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sync_direction_a: assert property (
        ok |-> hsync_oe_n_o == st.cfg1[2] && vsync_oe_n_o == st.cfg1[2])
        else $error("sync pin direction wrong");
    bus_float_a: assert property (
        reg_wr_i && reg_addr_i == `SVOP_ADDR_VM1 && reg_wdata_i[0] |-> ##[1:2] data_oe_n_o == 12'hFFF)
        else $error("data bus not floated");
    free_period_a: assert property (
        ok && !st.vm0[0] && pclk_o != st.pclk_q |-> st.run == half)
        else $error("free pclk half period wrong");
    ready_pulse_a: assert property (
        ok && st.vm0[0] && pclk_o != st.pclk_q && st.pclk_q == st.vm0[7] |-> st.run == half)
        else $error("ready pulse width wrong");
    data_edge_a: assert property (
        ok && !st.vm0[0] && !st.cfg1[2] && ($changed(data_o) || $changed(hsync_o))
        |-> pclk_o != st.pclk_q && pclk_o != st.vm0[1])
        else $error("data or line sync off the active edge");
    word_in_row_a: assert property (
        ok && st.vm0[0] && !st.cfg1[2] && pclk_o == st.vm0[7] |-> hsync_o == st.vm0[2])
        else $error("pixel strobe outside active line");
    frame_pulse_a: assert property (
        ok && st.vm0[4] && !st.vm0[5] && !st.cfg1[2] && vsync_o != st.vs_q
        && st.vs_q == st.vm0[3] |-> {1'b0, st.vrun} >= {half, 3'b000})
        else $error("frame pulse too short");
    rev_read_a: assert property (
        reg_rd_i && reg_addr_i == `SVOP_ADDR_REV |=> reg_rdata_o == SILICON_REV)
        else $error("revision read wrong");
endmodule // svop_video_port_chk
bind svop_video_port svop_video_port_chk #(.SILICON_REV(SILICON_REV)) u_chk (.clk_i, .rst_n_i,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .data_o, .data_oe_n_o,
    .pclk_o, .hsync_o, .hsync_oe_n_o, .vsync_o, .vsync_oe_n_o);
`default_nettype wire

/* File: svop_vp_model.sv */
// Video processor model: trigger source and pixel strobe capture
`timescale 1ns/100ps
`default_nettype none
module svop_vp_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic go_i,
    input wire logic pol_low_i,
    input wire logic cap_lvl_i,
    input wire logic pclk_i,
    input wire svop_pkg::svop_pix_t data_i,
    output logic row_trig_o,
    output logic frame_trig_o,
    output logic [15:0] words_o,
    output svop_pkg::svop_pix_t last_o,
    output logic [15:0] first_o
);
    import svop_pkg::*;
    logic [7:0] t;
    logic [15:0] age;
    logic pq;
    // Row trigger held three cycles, frame trigger ten cycles after it
    assign row_trig_o = pol_low_i ^ (t < 8'h03);
    assign frame_trig_o = pol_low_i ^ (t >= 8'h0A && t < 8'h0C);
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            t <= 8'hFF;
            age <= 16'h0000;
            pq <= 1'b1;
            words_o <= 16'h0000;
            last_o <= 12'h000;
            first_o <= 16'h0000;
        end else begin
            t <= go_i ? 8'h00 : t + {7'h00, t != 8'hFF};
            age <= go_i ? 16'h0000 : age + 16'h0001;
            pq <= pclk_i;
            if (go_i) begin
                words_o <= 16'h0000;
            end else if (pclk_i != pq && pclk_i == cap_lvl_i) begin
                words_o <= words_o + 16'h0001;
                last_o <= data_i;
                if (words_o == 16'h0000) first_o <= age;
            end
        end
    end
endmodule // svop_vp_model
`default_nettype wire

/* File: svop_video_port_bench.sv */
// Testbench for the sensor video output port
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin failures++; \
    $display("[FAIL] %s exp %h got %h", n, e, s); end end
module svop_video_port_bench;
    import svop_pkg::*;
    localparam logic [7:0] SILICON_REVISION = 8'h5A; // Arbitrary value
    localparam logic [7:0] RA [11] = '{8'h00, 8'h01, 8'h03, 8'h05, 8'h06, 8'h07, 8'h08,
        8'h10, 8'h11, 8'h12, 8'h23};
    localparam logic [7:0] RV [11] = '{8'h00, SILICON_REVISION, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00,
        8'h00, 8'hA5, 8'h32, 8'h00};
    localparam logic [7:0] MC [6] = '{8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] MV [6] = '{8'h00, 8'h02, 8'h00, 8'h11, 8'h95, 8'h35};
    logic clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, d;
    logic pix_valid_i = 1'b0, go = 1'b0, pol_low = 1'b0, cap_lvl = 1'b0, feed = 1'b0;
    svop_pix_t pix_data_i = 12'h000, data_o, last_word;
    svop_byte_t reg_rdata_o;
    logic [11:0] data_oe_n_o;
    logic pix_ready_o, pclk_o, pclk_oe_n_o, hsync_i, hsync_o, hsync_oe_n_o;
    logic vsync_i, vsync_o, vsync_oe_n_o, row_trig, frame_trig;
    logic [15:0] words, first_word;
    int failures = 0, checks = 0, n;
    // Pins resolve to whichever side drives them
    assign hsync_i = hsync_oe_n_o ? row_trig : hsync_o;
    assign vsync_i = vsync_oe_n_o ? frame_trig : vsync_o;
    svop_video_port #(.H_TOTAL(40), .V_ACTIVE(4), .V_TOTAL(6), .SILICON_REV(SILICON_REVISION)) dut (
        .clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .pix_valid_i, .pix_data_i, .pix_ready_o, .data_o, .data_oe_n_o, .pclk_o,
        .pclk_oe_n_o, .hsync_i, .hsync_o, .hsync_oe_n_o, .vsync_i, .vsync_o, .vsync_oe_n_o);
    svop_vp_model vp (.clk_i, .rst_n_i, .go_i(go), .pol_low_i(pol_low), .cap_lvl_i(cap_lvl),
        .pclk_i(pclk_o), .data_i(data_o), .row_trig_o(row_trig), .frame_trig_o(frame_trig),
        .words_o(words), .last_o(last_word), .first_o(first_word));
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        @(posedge clk_i);
        v = reg_rdata_o;
    endtask
    task automatic trig();
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    // Whole run needs about 8500 cycles
    initial begin
        repeat (40000) @(posedge clk_i);
        failures++;
        summarize();
    end
    always @(posedge clk_i) begin
        if (feed) begin
            pix_valid_i <= 1'b1;
            if (pix_valid_i && pix_ready_o) pix_data_i <= pix_data_i + 12'h001;
        end
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        wr(8'h23, 8'h00);
        wr(8'h01, 8'hFF);
        for (int i = 0; i < 11; i++) begin
            rd(RA[i], d);
            `CHK("register value", RV[i], d)
        end
        $display("test registers done");
        wr(8'h05, 8'h00);
        wr(8'h10, 8'h01);
        wr(8'h11, 8'h05);
        wr(8'h00, 8'h01);
        rd(8'h00, d);
        `CHK("commit pending", 8'h01, d)
        n = 0;
        while (d !== 8'h00 && n < 800) begin
            rd(8'h00, d);
            n++;
        end
        `CHK("commit cleared", 8'h00, d)
        // One frame is 240 ticks of two cycles, one read every two cycles
        `CHK("commit within a frame", 1'b1, n <= 240)
        feed <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            wr(8'h03, MC[i]);
            wr(8'h06, MV[i]);
            cap_lvl <= MV[i][7];
            trig();
            repeat (1000) @(posedge clk_i);
            `CHK("words captured", 1'b1, words != 16'h0000)
        end
        feed <= 1'b0;
        @(posedge clk_i);
        pix_valid_i <= 1'b0;
        repeat (1000) @(posedge clk_i);
        `CHK("fifo drained", 1'b1, pix_ready_o)
        $display("test leader done");
        wr(8'h03, 8'h04);
        wr(8'h06, 8'h01);
        wr(8'h08, 8'h19);
        wr(8'h10, 8'h02);
        wr(8'h11, 8'h03);
        wr(8'h00, 8'h01);
        cap_lvl <= 1'b0;
        `CHK("sync pins released", 2'b11, {hsync_oe_n_o, vsync_oe_n_o})
        `CHK("pclk driven", 1'b0, pclk_oe_n_o)
        trig();
        repeat (300) @(posedge clk_i);
        rd(8'h00, d);
        `CHK("commit on frame trigger", 8'h00, d)
        // Polarity swap makes a stray trigger while the buffer is empty
        wr(8'h06, 8'h41);
        pol_low <= 1'b1;
        repeat (300) @(posedge clk_i);
        n = 0;
        pix_valid_i <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            pix_data_i <= (i == 7) ? 12'h901 : 12'h100 + 12'(i);
            @(posedge clk_i);
            if (pix_ready_o !== 1'b1) break;
            n++;
        end
        pix_valid_i <= 1'b0;
        `CHK("words held", 8, n)
        trig();
        n = 0;
        while (words != 16'h0008 && n < 600) begin
            @(posedge clk_i);
            n++;
        end
        repeat (200) @(posedge clk_i);
        `CHK("words after trigger", 16'h0008, words)
        `CHK("first word delay", 1'b1, first_word >= 16'h007E && first_word <= 16'h0086)
        `CHK("saturated word", 12'hFFF, last_word)
        `CHK("unused pins floated", 12'h00F, data_oe_n_o)
        wr(8'h07, 8'h01);
        @(posedge clk_i);
        `CHK("bus floated", 12'hFFF, data_oe_n_o)
        // Let the float assertion finish before the run ends
        repeat (2) @(posedge clk_i);
        $display("test follower done");
        summarize();
    end
endmodule // svop_video_port_bench
`default_nettype wire
